// >>> bench/lrx_dma_control_props.sv
// Purpose: port checks of the lan receive dma control block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the design
module lrx_dma_control_props import lrx_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lrx_pkg::LRX_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lrx_pkg::lrx_dma_word_t dmaOut,
    input wire logic dmaValid,
    input wire logic dmaReady,
    input wire logic pauseFrameReq,
    input wire logic backpressureReq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // address of the read in flight, for field checks on the answer
    logic [15:0] rdAddr_r;
    always_ff @(posedge clk_sys) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rdAddr_r <= s_axi_araddr;
        end
    end
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles after request");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    dma_hold_a: assert property (dmaValid && !dmaReady |=> dmaValid &&
        $stable(dmaOut)) else $error("dma word changed while stalled");
    flow_excl_a: assert property (!(pauseFrameReq && backpressureReq))
        else $error("pause and backpressure together");
    rsvd_zero_a: assert property (s_axi_rvalid &&
        rdAddr_r == LRX_RXCTRL_ADDR |-> (s_axi_rdata & ~LRX_RXCTRL_WMASK) == 0)
        else $error("reserved control bits read nonzero");
    unmapped_zero_a: assert property (s_axi_rvalid &&
        s_axi_rresp == LRX_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    cover property (dmaValid && dmaReady && dmaOut.frameLast);
    cover property (pauseFrameReq);
    cover property (backpressureReq);
endmodule : lrx_dma_control_props
bind lrx_dma_control lrx_dma_control_props u_props (.*);

// >>> bench/lrx_dma_control_tb_top.sv
// Purpose: directed bench of the lan receive dma control block
// Assumes: partner model feeds frames, bench masters the register bus
// Notes: outputs sampled at falling edges, taken at rising edges
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
        n_mismatch++; \
    end \
end
module lrx_dma_control_tb_top import lrx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset_n, dmaValid, dmaReady, pauseFrameReq, backpressureReq;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, rxValid, rxReady;
    lrx_rx_word_t rxIn;
    lrx_dma_word_t dmaOut;
    int n_mismatch = 0, comparisons = 0, drops = 0;
    lrx_dma_control uut (.*);
    lrx_phy_model phy (.*);
    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic tmo(input string nm);
        $display("[FAIL] %s exp handshake got timeout", nm);
        n_mismatch++;
        summarize();
    endtask : tmo
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic aw, w, bv;
        bv = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (int i = 0; i < 50 && !bv; i++) begin
            @(negedge clk_sys);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            bv = s_axi_bvalid;
            if (bv) `CHK("bresp", LRX_RESP_OKAY, s_axi_bresp)
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
        if (!bv) tmo("write");
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic t, got;
        got = 1'b0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (int i = 0; i < 50 && !got; i++) begin
            @(negedge clk_sys);
            t = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
        if (!got) tmo("read");
    endtask : rd
    task automatic rchk(input logic [15:0] a, input logic [31:0] e,
                        input string nm);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK(nm, e, d)
    endtask : rchk
    // lo holds the expected fill and congestion flags of the status word
    task automatic dchk(input logic [15:0] lo);
        rchk(LRX_STATUS_ADDR, {8'h0, drops[7:0], lo}, "drop count");
    endtask : dchk
    task automatic pop(input logic [31:0] d, input logic fl, input logic bl);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 200 && !seen; i++) begin
            @(negedge clk_sys);
            seen = dmaValid && dmaReady;
            if (seen) `CHK("dma word", {d, fl, bl}, dmaOut)
            @(posedge clk_sys);
        end
        if (!seen) tmo("dma word");
    endtask : pop
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        logic [31:0] d, w0, w1;
        logic [1:0] r;
        int i;
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, dmaReady} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        dmaReady <= 1'b1;
        @(posedge clk_sys);
        rchk(LRX_RXCTRL_ADDR, 32'h0, "ctrl reset");
        rchk(LRX_WMARK_ADDR, 32'h001c_0818, "wmark reset");
        rd(16'h8200, d, r);
        `CHK("unmapped resp", LRX_RESP_SLVERR, r)
        wr(LRX_RXCTRL_ADDR, 32'hffff_ffff);
        rchk(LRX_RXCTRL_ADDR, 32'h3f0f_8400, "ctrl mask");
        wr(LRX_RXCTRL_ADDR, 32'h0200_0000);
        fork
            phy.send(5, 7'h07);
            for (int k = 0; k < 5; k++) begin
                pop(phy.dat(k), k == 4, k % 2 == 1 || k == 4);
            end
        join
        wr(LRX_RXCTRL_ADDR, 32'h0008_0000);
        w0 = phy.dat(0);
        w1 = phy.dat(1);
        fork
            phy.send(2, 7'h27);
            begin
                pop({w0[15:0], 16'h0}, 1'b0, 1'b0);
                pop({w1[15:0], w0[31:16]}, 1'b0, 1'b0);
                pop({16'h0, w1[31:16]}, 1'b1, 1'b1);
            end
        join
        for (int j = 0; j < 3; j++) begin
            wr(LRX_RXCTRL_ADDR, 32'h1 << (16 + j));
            phy.send(2, {2'b11, j == 1, j == 2, j != 0, j != 1, j != 2});
            drops++;
        end
        dchk(16'h0000);
        wr(LRX_RXCTRL_ADDR, 32'h0);
        dmaReady <= 1'b0;
        repeat (3) phy.send(9, 7'h07);
        wr(LRX_RXCTRL_ADDR, 32'h0000_0400);
        phy.send(1, 7'h47);
        phy.send(1, 7'h07);
        drops++;
        wr(LRX_RXCTRL_ADDR, 32'h0);
        phy.send(1, 7'h47);
        drops++;
        dchk(16'h021a);
        wr(LRX_FLOWCFG_ADDR, 32'h3);
        rd(LRX_STATUS_ADDR, d, r);
        `CHK("pause", 1'b1, pauseFrameReq)
        `CHK("backpressure", 1'b0, backpressureReq)
        wr(LRX_FLOWCFG_ADDR, 32'h1);
        rd(LRX_STATUS_ADDR, d, r);
        `CHK("pause", 1'b0, pauseFrameReq)
        `CHK("backpressure", 1'b1, backpressureReq)
        wr(LRX_RXCTRL_ADDR, 32'h0000_0400);
        phy.send(1, 7'h07);
        dchk(16'h041b);
        dmaReady <= 1'b1;
        i = 0;
        do begin
            rd(LRX_STATUS_ADDR, d, r);
            i++;
        end while (d[5:0] != 6'h0 && i < 100);
        `CHK("drained status", {8'h0, drops[7:0], 16'h0}, d)
        `CHK("backpressure", 1'b0, backpressureReq)
        summarize();
    end
endmodule : lrx_dma_control_tb_top

// >>> bench/lrx_phy_model.sv
// Purpose: behavioural lan port source of framed receive words
// Assumes: words change after a rising edge and hold until taken
// Notes: idle lines show inverted data so stale words never match
module lrx_phy_model import lrx_pkg::*; (
    input wire logic clk_sys,
    output lrx_pkg::lrx_rx_word_t rxIn,
    output logic rxValid,
    input wire logic rxReady
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rxIn = '0;
        rxValid = 1'b0;
    end
    function automatic logic [31:0] dat(input int k);
        return {8'h5a, k[7:0], 8'hc3, ~k[7:0]};
    endfunction : dat
    // m is {highPrio, isIp, isTcp, isUdp, ipOk, tcpOk, udpOk} from classifier
    task automatic send(input int n, input logic [6:0] m);
        logic took;
        for (int k = 0; k < n; k++) begin
            rxIn <= lrx_rx_word_t'({dat(k), k == 0, k == n - 1, m});
            rxValid <= 1'b1;
            took = 1'b0;
            for (int i = 0; i < 100 && !took; i++) begin
                @(negedge clk_sys);
                took = rxReady;
                @(posedge clk_sys);
            end
            if (!took) lrx_dma_control_tb_top.tmo("rx word");
        end
        rxValid <= 1'b0;
        rxIn <= ~rxIn;
        // idle edge so a following frame never reassigns in this step
        @(posedge clk_sys);
    endtask : send
endmodule : lrx_phy_model

// >>> hw/lrx_dma_control.sv
// Purpose: receive control of a lan mac dma: burst, alignment, checks, drops
// Assumes: rx words arrive framed; meta from external checksum and classifier
// Notes: frames sit in a 32-word buffer and are released only when complete
// Operation
// - burst-size field bits 29:24 caps words moved per dma burst
// - burst size zero means bursts end only when buffered data runs out
// - alignment bit 19 puts ip header on a word boundary in memory
// - bit 18 set: udp frames with bad checksum are discarded
// - bit 17 set: tcp frames with bad checksum are discarded
// - bit 16 set: ip frames with bad header checksum are discarded
// - low-drop bit 10, flow control off: drop low priority at low hi mark
// - low-priority dropping persists until fill falls to the low watermark
// - no flow control, no low-drop: drop everything at low hi mark
// - low-drop only: low frames at low mark, all at high-prio mark
// - flow control on: pause or backpressure at low hi mark
// - flow control: pause in full duplex, backpressure in half duplex
module lrx_dma_control (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [lrx_pkg::LRX_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lrx_pkg::LRX_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lrx_pkg::lrx_rx_word_t rxIn,
    input wire logic rxValid,
    output logic rxReady,
    output lrx_pkg::lrx_dma_word_t dmaOut,
    output logic dmaValid,
    input wire logic dmaReady,
    output logic pauseFrameReq,
    output logic backpressureReq
);
    import lrx_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] flowCfg;
        logic [31:0] wmark;
        logic awHeld;
        logic [LRX_ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        lrx_rx_state_t rxState;
        logic alignOn;
        logic [15:0] carry;
        logic [LRX_DEPTH-1:0][32:0] mem;
        logic [LRX_PTR_W-1:0] wrPtr;
        logic [LRX_PTR_W-1:0] frmStart;
        logic [LRX_PTR_W-1:0] commitPtr;
        logic [LRX_PTR_W-1:0] rdPtr;
        logic [LRX_PTR_W-1:0] burstCnt;
        logic [1:0][$bits(lrx_dma_word_t)-1:0] fifo;
        logic [1:0] fifoCnt;
        logic lowDrop;
        logic allDrop;
        logic pause;
        logic [7:0] dropCnt;
    } lrx_state_t;

    lrx_state_t s_r;
    lrx_state_t s_nxt;

    logic [LRX_PTR_W-1:0] fill;
    logic [LRX_PTR_W-1:0] avail;
    logic bufFull;
    logic [LRX_BURST_W-1:0] burstLen;
    logic [LRX_WM_W-1:0] wmLowHi;
    logic [LRX_WM_W-1:0] wmLowLo;
    logic [LRX_WM_W-1:0] wmHiHi;
    logic txFcEn;
    logic lowDropEn;
    logic csumBad;
    logic rxFire;
    logic dmaPop;

    function automatic logic [31:0] lrx_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [31:0] mask
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r & mask;
    endfunction : lrx_merge

    assign fill = s_r.wrPtr - s_r.rdPtr;
    assign avail = s_r.commitPtr - s_r.rdPtr;
    assign bufFull = (fill == LRX_PTR_W'(LRX_DEPTH));
    assign burstLen = s_r.ctrl[LRX_BURST_LSB +: LRX_BURST_W];
    assign wmLowHi = s_r.wmark[LRX_WM_LOWHI_LSB +: LRX_WM_W];
    assign wmLowLo = s_r.wmark[LRX_WM_LOWLO_LSB +: LRX_WM_W];
    assign wmHiHi = s_r.wmark[LRX_WM_HIHI_LSB +: LRX_WM_W];
    assign txFcEn = s_r.flowCfg[LRX_TXFC_BIT];
    assign lowDropEn = s_r.ctrl[LRX_LOWDROP_BIT];
    // checksum verdicts are sampled with the last word of a frame
    assign csumBad =
        (s_r.ctrl[LRX_UDPCHK_BIT] && rxIn.isUdp && !rxIn.udpCsumOk) ||
        (s_r.ctrl[LRX_TCPCHK_BIT] && rxIn.isTcp && !rxIn.tcpCsumOk) ||
        (s_r.ctrl[LRX_IPCHK_BIT] && rxIn.isIp && !rxIn.ipCsumOk);

    // tail word needs a spare write slot, so input stalls there
    assign rxReady = (s_r.rxState != LRX_ST_TAIL);
    assign rxFire = rxValid && rxReady;
    assign dmaValid = (s_r.fifoCnt != 2'd0);
    assign dmaOut = lrx_dma_word_t'(s_r.fifo[0]);
    assign dmaPop = dmaValid && dmaReady;

    assign s_axi_awready = !s_r.awHeld && !s_r.bvalid;
    assign s_axi_wready = !s_r.wHeld && !s_r.bvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rdata = s_r.rdata;
    assign pauseFrameReq = s_r.pause && s_r.flowCfg[LRX_FULLDUP_BIT];
    assign backpressureReq = s_r.pause && !s_r.flowCfg[LRX_FULLDUP_BIT];

    always_comb begin
        logic startWord;
        logic wordPath;
        logic alignNow;
        logic [LRX_PTR_W-1:0] base;
        logic [15:0] carryIn;
        logic doPush;
        logic [1:0] cnt;
        logic [32:0] rdWord;
        lrx_dma_word_t pushWord;
        startWord = 1'b0;
        wordPath = 1'b0;
        alignNow = 1'b0;
        base = s_r.frmStart;
        carryIn = s_r.carry;
        doPush = 1'b0;
        cnt = s_r.fifoCnt;
        rdWord = s_r.mem[s_r.rdPtr[LRX_PTR_W-2:0]];
        pushWord = '0;
        s_nxt = s_r;

        // register write: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = s_axi_wdata;
            s_nxt.wStrb = s_axi_wstrb;
        end
        if (s_r.awHeld && s_r.wHeld) begin
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = LRX_RESP_OKAY;
            case (s_r.awAddr)
                LRX_RXCTRL_ADDR: begin
                    s_nxt.ctrl = lrx_merge(s_r.ctrl, s_r.wData, s_r.wStrb,
                        LRX_RXCTRL_WMASK);
                end
                LRX_FLOWCFG_ADDR: begin
                    s_nxt.flowCfg = lrx_merge(s_r.flowCfg, s_r.wData,
                        s_r.wStrb, LRX_FLOWCFG_WMASK);
                end
                LRX_WMARK_ADDR: begin
                    s_nxt.wmark = lrx_merge(s_r.wmark, s_r.wData, s_r.wStrb,
                        LRX_WMARK_WMASK);
                end
                default: begin
                    s_nxt.bresp = LRX_RESP_SLVERR;
                end
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // register read
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = LRX_RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                LRX_RXCTRL_ADDR: s_nxt.rdata = s_r.ctrl;
                LRX_FLOWCFG_ADDR: s_nxt.rdata = s_r.flowCfg;
                LRX_WMARK_ADDR: s_nxt.rdata = s_r.wmark;
                LRX_STATUS_ADDR: begin
                    s_nxt.rdata[LRX_ST_FILL_LSB +: LRX_PTR_W] = fill;
                    s_nxt.rdata[LRX_ST_LOWDROP_BIT] = s_r.lowDrop;
                    s_nxt.rdata[LRX_ST_ALLDROP_BIT] = s_r.allDrop;
                    s_nxt.rdata[LRX_ST_PAUSE_BIT] = s_r.pause;
                    s_nxt.rdata[LRX_ST_DROPCNT_LSB +: 8] = s_r.dropCnt;
                end
                default: s_nxt.rresp = LRX_RESP_SLVERR;
            endcase
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // congestion policy on total fill, including the frame being written
        if (!txFcEn && lowDropEn) begin
            if (fill >= wmLowHi) begin
                s_nxt.lowDrop = 1'b1;
            end else if (fill <= wmLowLo) begin
                s_nxt.lowDrop = 1'b0;
            end
        end else begin
            s_nxt.lowDrop = 1'b0;
        end
        s_nxt.allDrop = !txFcEn && (lowDropEn ? (fill >= wmHiHi)
                                              : (fill >= wmLowHi));
        s_nxt.pause = txFcEn && (fill >= wmLowHi);

        // receive side: admission at the first word, verdict at the last
        case (s_r.rxState)
            LRX_ST_IDLE: begin
                if (rxFire && rxIn.first) begin
                    // priority is supplied by the outside classifier
                    if (s_r.allDrop || (s_r.lowDrop && !rxIn.highPrio)) begin
                        s_nxt.dropCnt = s_r.dropCnt + 8'h01;
                        if (!rxIn.last) begin
                            s_nxt.rxState = LRX_ST_DROP;
                        end
                    end else begin
                        startWord = 1'b1;
                    end
                end
            end
            LRX_ST_PASS: begin
                wordPath = rxFire;
            end
            LRX_ST_DROP: begin
                if (rxFire && rxIn.last) begin
                    s_nxt.rxState = LRX_ST_IDLE;
                end
            end
            LRX_ST_TAIL: begin
                if (bufFull) begin
                    s_nxt.wrPtr = s_r.frmStart;
                    s_nxt.dropCnt = s_r.dropCnt + 8'h01;
                end else begin
                    s_nxt.mem[s_r.wrPtr[LRX_PTR_W-2:0]] =
                        {1'b1, 16'h0000, s_r.carry};
                    s_nxt.wrPtr = s_r.wrPtr + 6'h01;
                    s_nxt.commitPtr = s_r.wrPtr + 6'h01;
                end
                s_nxt.rxState = LRX_ST_IDLE;
            end
            default: begin
                s_nxt.rxState = LRX_ST_IDLE;
            end
        endcase

        if (startWord) begin
            wordPath = 1'b1;
            base = s_r.wrPtr;
            carryIn = 16'h0000;
            alignNow = s_r.ctrl[LRX_ALIGN_BIT] && rxIn.isIp;
        end else begin
            alignNow = s_r.alignOn;
        end

        if (wordPath) begin
            s_nxt.frmStart = base;
            s_nxt.alignOn = alignNow;
            if (bufFull || (rxIn.last && csumBad)) begin
                // rewind: the partial frame is never seen by the dma side
                s_nxt.wrPtr = base;
                s_nxt.dropCnt = s_r.dropCnt + 8'h01;
                s_nxt.rxState = rxIn.last ? LRX_ST_IDLE : LRX_ST_DROP;
            end else begin
                // two pad bytes shift the 14-byte mac header to 16 bytes
                s_nxt.mem[s_r.wrPtr[LRX_PTR_W-2:0]] = alignNow ?
                    {1'b0, rxIn.data[15:0], carryIn} :
                    {rxIn.last, rxIn.data};
                s_nxt.wrPtr = s_r.wrPtr + 6'h01;
                s_nxt.carry = rxIn.data[31:16];
                if (!rxIn.last) begin
                    s_nxt.rxState = LRX_ST_PASS;
                end else if (alignNow) begin
                    s_nxt.rxState = LRX_ST_TAIL;
                end else begin
                    s_nxt.commitPtr = s_r.wrPtr + 6'h01;
                    s_nxt.rxState = LRX_ST_IDLE;
                end
            end
        end

        // dma side: two-entry buffer fed from committed words
        if (dmaPop) begin
            s_nxt.fifo[0] = s_r.fifo[1];
            cnt = s_r.fifoCnt - 2'd1;
        end
        doPush = (avail != 6'h00) && (cnt != 2'd2);
        if (doPush) begin
            pushWord.data = rdWord[31:0];
            pushWord.frameLast = rdWord[32];
            // zero length: burst ends only when buffered data runs out
            pushWord.burstLast = (avail == 6'h01) ||
                ((burstLen != 6'h00) &&
                 (6'(s_r.burstCnt + 6'h01) == burstLen));
            s_nxt.burstCnt = pushWord.burstLast ? 6'h00
                                                : s_r.burstCnt + 6'h01;
            s_nxt.fifo[cnt[0]] = pushWord;
            s_nxt.rdPtr = s_r.rdPtr + 6'h01;
            cnt = cnt + 2'd1;
        end
        s_nxt.fifoCnt = cnt;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.ctrl <= LRX_RXCTRL_RESET;
            s_r.flowCfg <= LRX_FLOWCFG_RESET;
            s_r.wmark <= LRX_WMARK_RESET;
            s_r.rxState <= LRX_ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : lrx_dma_control

// >>> hw/lrx_pkg.sv
// Purpose: constants and carrier types of the lan receive dma control block
// Assumes: 32-bit axi4-lite register bus, one clock domain
// Notes: byte addresses are the register offsets themselves
package lrx_pkg;
    // receive buffer geometry and register address width
    localparam int LRX_DEPTH = 32;
    localparam int LRX_PTR_W = 6;
    localparam int LRX_ADDR_W = 16;
    // register byte addresses
    localparam logic [15:0] LRX_RXCTRL_ADDR = 16'h8004;
    localparam logic [15:0] LRX_FLOWCFG_ADDR = 16'h8100;
    localparam logic [15:0] LRX_WMARK_ADDR = 16'h8104;
    localparam logic [15:0] LRX_STATUS_ADDR = 16'h8108;
    // writable bits and reset values
    localparam logic [31:0] LRX_RXCTRL_WMASK = 32'h3f0f_8400;
    localparam logic [31:0] LRX_RXCTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] LRX_FLOWCFG_WMASK = 32'h0000_0003;
    localparam logic [31:0] LRX_FLOWCFG_RESET = 32'h0000_0000;
    localparam logic [31:0] LRX_WMARK_WMASK = 32'h003f_3f3f;
    localparam logic [31:0] LRX_WMARK_RESET = 32'h001c_0818;
    // receive control fields
    localparam int LRX_BURST_LSB = 24;
    localparam int LRX_BURST_W = 6;
    localparam int LRX_ALIGN_BIT = 19;
    localparam int LRX_UDPCHK_BIT = 18;
    localparam int LRX_TCPCHK_BIT = 17;
    localparam int LRX_IPCHK_BIT = 16;
    localparam int LRX_LOWDROP_BIT = 10;
    // flow configuration fields
    localparam int LRX_TXFC_BIT = 0;
    localparam int LRX_FULLDUP_BIT = 1;
    // watermark fields, in buffer words
    localparam int LRX_WM_LOWHI_LSB = 0;
    localparam int LRX_WM_LOWLO_LSB = 8;
    localparam int LRX_WM_HIHI_LSB = 16;
    localparam int LRX_WM_W = 6;
    // status fields
    localparam int LRX_ST_FILL_LSB = 0;
    localparam int LRX_ST_LOWDROP_BIT = 8;
    localparam int LRX_ST_ALLDROP_BIT = 9;
    localparam int LRX_ST_PAUSE_BIT = 10;
    localparam int LRX_ST_DROPCNT_LSB = 16;
    // axi responses
    localparam logic [1:0] LRX_RESP_OKAY = 2'b00;
    localparam logic [1:0] LRX_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [31:0] data;
        logic first;
        logic last;
        logic highPrio;
        logic isIp;
        logic isTcp;
        logic isUdp;
        logic ipCsumOk;
        logic tcpCsumOk;
        logic udpCsumOk;
    } lrx_rx_word_t;

    typedef struct packed {
        logic [31:0] data;
        logic frameLast;
        logic burstLast;
    } lrx_dma_word_t;

    typedef enum logic [1:0] {
        LRX_ST_IDLE = 2'b00,
        LRX_ST_PASS = 2'b01,
        LRX_ST_TAIL = 2'b11,
        LRX_ST_DROP = 2'b10
    } lrx_rx_state_t;
endpackage : lrx_pkg
